// file: src/alu_datapath.sv
// Execution datapath: arithmetic, logic, shift and bit operations.
//
// Behaviour
// - Add or subtract two registers; add immediate.
// - Plain subtract never takes an immediate operand.
// - Word add and subtract use registers only.
// - Byte add and subtract including the carry.
// - Byte increment or decrement by exactly one.
// - Word step add or subtract, one or two.
// - Decimal adjust byte using carry and half-carry.
// - Unsigned byte times byte gives word.
// - Word over byte gives quotient and remainder.
// - Compare subtracts; word compare registers only.
// - Negate byte as zero minus value.
// - Byte AND, OR, XOR with register or immediate.
// - Invert every bit of a byte.
// - Arithmetic shift left and right by one.
// - Logical shift left and right by one.
// - Plain rotates and rotates through the carry.
// - Bit number from immediate or register low bits.
// - Set selected bit, others unchanged.
// - Clear selected bit, others unchanged.
// - Invert selected bit and write byte back.
// - Test loads zero flag with inverted bit.
// - Carry combined with bit by AND, OR, XOR.
// - Inverted-bit carry ops take immediate bit only.
// - Bit changes write back the whole byte.
`timescale 1ns/100ps
module alu_datapath
	import alu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	input wire alu_op_t op_in,
	input wire logic size_word,
	input wire logic use_imm,
	input wire logic bit_from_reg,
	input wire logic [2:0] bit_num_imm,
	input wire logic [DATA_W-1:0] rd_val,
	input wire logic [DATA_W-1:0] rs_val,
	input wire logic [DATA_W-1:0] imm_val,
	input wire logic [FLG_W-1:0] flags_in,
	output logic out_valid_ff,
	output logic [DATA_W-1:0] result_ff,
	output logic result_write_ff,
	output logic [FLG_W-1:0] flags_ff,
	output logic illegal_ff
);
	logic [BYTE_W-1:0] rd_lo;
	logic [DATA_W-1:0] opb;
	logic [BYTE_W-1:0] opb_lo;
	logic [2:0] bit_sel;
	logic sel_bit;
	logic [BYTE_W-1:0] bit_mask;
	logic [BYTE_W-1:0] sh_res;
	logic sh_c;
	logic sh_v;
	logic [DATA_W-1:0] mul_prod;
	logic [BYTE_W-1:0] div_q;
	logic [BYTE_W-1:0] div_r;
	logic [DATA_W-1:0] nxt_result;
	logic [FLG_W-1:0] nxt_flags;
	logic nxt_write;
	logic nxt_illegal;

	assign rd_lo = rd_val[BYTE_W-1:0];
	assign opb = use_imm ? imm_val : rs_val;
	assign opb_lo = opb[BYTE_W-1:0];
	assign bit_sel = bit_from_reg ? rs_val[2:0] : bit_num_imm;
	assign sel_bit = rd_lo[bit_sel];
	assign bit_mask = BIT_ONE << bit_sel;

	alu_shift_unit #(.W(BYTE_W)) u_shift (
		.op(op_in),
		.val(rd_lo),
		.cin(flags_in[FC]),
		.res(sh_res),
		.cout(sh_c),
		.vout(sh_v)
	);

	alu_muldiv_unit #(.W(BYTE_W)) u_muldiv (
		.dividend(rd_val),
		.mul_a(rd_lo),
		.divisor(rs_val[BYTE_W-1:0]),
		.product(mul_prod),
		.quotient(div_q),
		.remainder(div_r)
	);

	// Returns the flags above the sum; carry and half-carry read as borrow for subtraction.
	function automatic logic [FLG_W+DATA_W-1:0] arith(input logic [DATA_W-1:0] a,
			input logic [DATA_W-1:0] b, input logic cin, input logic sub,
			input logic word, input logic zin);
		logic [DATA_W-1:0] bb;
		logic ci;
		logic [DATA_W:0] s;
		logic [4:0] hs;
		logic [12:0] hw;
		logic [DATA_W-1:0] r;
		logic [FLG_W-1:0] f;
		bb = sub ? ~b : b;
		ci = cin ^ sub;
		f = FLAGS_RST;
		if (word) begin
			s = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
			hw = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, ci};
			r = s[DATA_W-1:0];
			f[FC] = s[DATA_W] ^ sub;
			f[FH] = hw[12] ^ sub;
			f[FV] = (a[15] == bb[15]) && (r[15] != a[15]);
			f[FN] = r[15];
		end else begin
			s = {9'h000, a[7:0]} + {9'h000, bb[7:0]} + {16'h0000, ci};
			hs = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
			r = {8'h00, s[7:0]};
			f[FC] = s[8] ^ sub;
			f[FH] = hs[4] ^ sub;
			f[FV] = (a[7] == bb[7]) && (r[7] != a[7]);
			f[FN] = r[7];
		end
		f[FZ] = (r == RESULT_RST) && zin;
		return {f, r};
	endfunction

	always_comb begin
		logic [FLG_W+DATA_W-1:0] ar;
		logic [BYTE_W-1:0] da;
		logic dc;
		ar = '0;
		da = rd_lo;
		dc = flags_in[FC];
		nxt_result = rd_val;
		nxt_flags = flags_in;
		nxt_write = 1'b1;
		nxt_illegal = 1'b0;
		case (op_in)
			OP_ADD: begin
				ar = arith(rd_val, opb, 1'b0, 1'b0, size_word, 1'b1);
				nxt_illegal = size_word && use_imm;
			end
			OP_SUB: begin
				ar = arith(rd_val, rs_val, 1'b0, 1'b1, size_word, 1'b1);
				nxt_illegal = use_imm;
			end
			OP_ADD_CARRY: begin
				ar = arith({8'h00, rd_lo}, {8'h00, opb_lo}, flags_in[FC], 1'b0, 1'b0,
					flags_in[FZ]);
			end
			OP_SUB_CARRY: begin
				ar = arith({8'h00, rd_lo}, {8'h00, opb_lo}, flags_in[FC], 1'b1, 1'b0,
					flags_in[FZ]);
			end
			OP_INC, OP_DEC: begin
				ar = arith({8'h00, rd_lo}, BYTE_STEP, 1'b0, op_in == OP_DEC, 1'b0,
					1'b1);
				// Stepping leaves carry and half-carry alone so loop counters keep them.
				ar[DATA_W + FC] = flags_in[FC];
				ar[DATA_W + FH] = flags_in[FH];
			end
			OP_CMP: begin
				ar = arith(rd_val, opb, 1'b0, 1'b1, size_word, 1'b1);
				nxt_illegal = size_word && use_imm;
			end
			OP_NEG: begin
				ar = arith(RESULT_RST, {8'h00, rd_lo}, 1'b0, 1'b1, 1'b0, 1'b1);
			end
			default: begin
				ar = '0;
			end
		endcase
		case (op_in)
			OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_CARRY, OP_INC, OP_DEC, OP_NEG: begin
				nxt_result = ar[DATA_W-1:0];
				nxt_flags = ar[FLG_W+DATA_W-1:DATA_W];
			end
			OP_CMP: begin
				nxt_flags = ar[FLG_W+DATA_W-1:DATA_W];
				nxt_write = 1'b0;
			end
			OP_WORD_ADD_STEP, OP_WORD_SUB_STEP: begin
				nxt_illegal = (imm_val != WORD_STEP_ONE) && (imm_val != WORD_STEP_TWO);
				nxt_result = (op_in == OP_WORD_ADD_STEP) ? rd_val + imm_val : rd_val - imm_val;
			end
			OP_DEC_ADJ_ADD: begin
				if (flags_in[FC] || (rd_lo > BCD_LIM)) begin
					da = da + BCD_HI_ADJ;
					dc = 1'b1;
				end
				if (flags_in[FH] || (rd_lo[3:0] > NIB_LIM)) begin
					da = da + BCD_LO_ADJ;
				end
				nxt_result = {8'h00, da};
			end
			OP_DEC_ADJ_SUB: begin
				if (flags_in[FC]) begin
					da = da - BCD_HI_ADJ;
				end
				if (flags_in[FH]) begin
					da = da - BCD_LO_ADJ;
				end
				nxt_result = {8'h00, da};
			end
			OP_MUL: begin
				nxt_result = mul_prod;
			end
			OP_DIV: begin
				nxt_result = {div_r, div_q};
				nxt_flags[FN] = div_q[BYTE_W-1];
				nxt_flags[FZ] = (rs_val[BYTE_W-1:0] == 8'h00);
			end
			OP_AND: begin
				nxt_result = {8'h00, rd_lo & opb_lo};
			end
			OP_OR: begin
				nxt_result = {8'h00, rd_lo | opb_lo};
			end
			OP_XOR: begin
				nxt_result = {8'h00, rd_lo ^ opb_lo};
			end
			OP_NOT: begin
				nxt_result = {8'h00, ~rd_lo};
			end
			OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT,
			OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
			OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY: begin
				nxt_result = {8'h00, sh_res};
				nxt_flags[FC] = sh_c;
				nxt_flags[FV] = sh_v;
			end
			OP_BIT_SET: begin
				nxt_result = {8'h00, rd_lo | bit_mask};
			end
			OP_BIT_CLEAR: begin
				nxt_result = {8'h00, rd_lo & ~bit_mask};
			end
			OP_BIT_INVERT: begin
				nxt_result = {8'h00, rd_lo ^ bit_mask};
			end
			OP_BIT_TEST: begin
				nxt_flags[FZ] = ~sel_bit;
				nxt_write = 1'b0;
			end
			OP_CARRY_AND_BIT, OP_CARRY_OR_BIT, OP_CARRY_XOR_BIT: begin
				nxt_write = 1'b0;
				if (op_in == OP_CARRY_AND_BIT) begin
					nxt_flags[FC] = flags_in[FC] & sel_bit;
				end else if (op_in == OP_CARRY_OR_BIT) begin
					nxt_flags[FC] = flags_in[FC] | sel_bit;
				end else begin
					nxt_flags[FC] = flags_in[FC] ^ sel_bit;
				end
			end
			OP_CARRY_AND_INV_BIT, OP_CARRY_OR_INV_BIT: begin
				nxt_write = 1'b0;
				nxt_illegal = bit_from_reg;
				if (op_in == OP_CARRY_AND_INV_BIT) begin
					nxt_flags[FC] = flags_in[FC] & ~sel_bit;
				end else begin
					nxt_flags[FC] = flags_in[FC] | ~sel_bit;
				end
			end
			default: begin
				nxt_illegal = 1'b1;
			end
		endcase
		case (op_in)
			OP_AND, OP_OR, OP_XOR, OP_NOT, OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT,
			OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
			OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY,
			OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB: begin
				nxt_flags[FN] = nxt_result[BYTE_W-1];
				nxt_flags[FZ] = (nxt_result[BYTE_W-1:0] == 8'h00);
				if (op_in == OP_DEC_ADJ_ADD) begin
					nxt_flags[FC] = dc;
				end
				if (op_in < OP_ARITH_SHIFT_LEFT || op_in > OP_ROTATE_RIGHT_VIA_CARRY) begin
					nxt_flags[FV] = 1'b0;
				end
			end
			default: begin
				nxt_flags[FN] = nxt_flags[FN];
			end
		endcase
		if (nxt_illegal) begin
			nxt_result = rd_val;
			nxt_flags = flags_in;
			nxt_write = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			result_write_ff <= 1'b0;
			illegal_ff <= 1'b0;
		end else begin
			out_valid_ff <= in_valid;
			result_write_ff <= in_valid && nxt_write;
			illegal_ff <= in_valid && nxt_illegal;
		end
	end

	// Result and flags hold between operations so the decoder may sample late.
	always_ff @(posedge clock) begin
		if (rst) begin
			result_ff <= RESULT_RST;
		end else if (in_valid) begin
			result_ff <= nxt_result;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			flags_ff <= FLAGS_RST;
		end else if (in_valid) begin
			flags_ff <= nxt_flags;
		end
	end

	sequence s_issue(alu_op_t o);
		in_valid && op_in == o;
	endsequence

	chk_add_byte_sum: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_ADD) ##0 (!size_word && !use_imm) |=> result_write_ff &&
		result_ff[7:0] == 8'($past(rd_lo) + $past(opb_lo)))
		else $error("byte add result wrong");
	chk_sub_imm_refused: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_SUB) ##0 use_imm |=> illegal_ff && !result_write_ff)
		else $error("subtract with immediate accepted");
	chk_word_imm_refused: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_ADD) ##0 (size_word && use_imm) |=> illegal_ff &&
		result_ff == $past(rd_val))
		else $error("word add with immediate accepted");
	chk_inc_by_one: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_INC) |=> result_ff[7:0] == 8'($past(rd_lo) + 8'h01))
		else $error("increment not by one");
	chk_step_range: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_WORD_ADD_STEP) ##0 (imm_val > WORD_STEP_TWO || imm_val == 16'h0000)
		|=> illegal_ff)
		else $error("word step outside one or two accepted");
	chk_mul_product: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_MUL) |=> result_ff == ({8'h00, $past(rd_lo)} *
		{8'h00, $past(rs_val[7:0])}))
		else $error("product wrong");
	chk_cmp_no_write: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_CMP) ##0 !size_word ##0 (rd_lo == opb_lo) |=> !result_write_ff &&
		flags_ff[FZ] && out_valid_ff)
		else $error("compare wrote or missed zero");
	chk_neg_value: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_NEG) |=> result_ff[7:0] == 8'(8'h00 - $past(rd_lo)))
		else $error("negate wrong");
	chk_not_value: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_NOT) |=> (result_ff[7:0] ^ $past(rd_lo)) == 8'hff)
		else $error("invert wrong");
	chk_bit_set_one: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_BIT_SET) |=> result_ff[$past(bit_sel)] && result_write_ff)
		else $error("set bit not one");
	chk_test_zero: assert property (@(posedge clock) disable iff (rst)
		s_issue(OP_BIT_TEST) |=> flags_ff[FZ] == !$past(sel_bit) && !result_write_ff)
		else $error("bit test zero flag wrong");
endmodule

// file: src/alu_pkg.sv
// Shared constants, flag layout and operation codes for the ALU datapath.
package alu_pkg;
	localparam int FLG_W = 5;
	localparam int FC = 0;
	localparam int FV = 1;
	localparam int FZ = 2;
	localparam int FN = 3;
	localparam int FH = 4;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int LAT_CYCLES = 1;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam logic [15:0] WORD_STEP_ONE = 16'h0001;
	localparam logic [15:0] WORD_STEP_TWO = 16'h0002;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [7:0] BCD_LIM = 8'h99;
	localparam logic [3:0] NIB_LIM = 4'h9;
	localparam logic [7:0] BCD_LO_ADJ = 8'h06;
	localparam logic [7:0] BCD_HI_ADJ = 8'h60;
	localparam logic [7:0] BIT_ONE = 8'h01;

	typedef enum logic [5:0] {
		OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_CARRY, OP_INC, OP_DEC,
		OP_WORD_ADD_STEP, OP_WORD_SUB_STEP, OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB,
		OP_MUL, OP_DIV, OP_CMP, OP_NEG,
		OP_AND, OP_OR, OP_XOR, OP_NOT,
		OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT,
		OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
		OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
		OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY,
		OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_INVERT, OP_BIT_TEST,
		OP_CARRY_AND_BIT, OP_CARRY_AND_INV_BIT,
		OP_CARRY_OR_BIT, OP_CARRY_OR_INV_BIT, OP_CARRY_XOR_BIT
	} alu_op_t;
endpackage

// file: src/alu_shift_unit.sv
// Byte shifter and rotator with carry and overflow outputs.
`timescale 1ns/100ps
module alu_shift_unit
	import alu_pkg::*;
#(
	parameter int W = 8
) (
	input wire alu_op_t op,
	input wire logic [W-1:0] val,
	input wire logic cin,
	output logic [W-1:0] res,
	output logic cout,
	output logic vout
);
	always_comb begin
		res = val;
		cout = cin;
		vout = 1'b0;
		case (op)
			OP_ARITH_SHIFT_LEFT: begin
				res = {val[W-2:0], 1'b0};
				cout = val[W-1];
				vout = val[W-1] ^ val[W-2];
			end
			OP_ARITH_SHIFT_RIGHT: begin
				res = {val[W-1], val[W-1:1]};
				cout = val[0];
			end
			OP_LOGIC_SHIFT_LEFT: begin
				res = {val[W-2:0], 1'b0};
				cout = val[W-1];
			end
			OP_LOGIC_SHIFT_RIGHT: begin
				res = {1'b0, val[W-1:1]};
				cout = val[0];
			end
			OP_ROTATE_LEFT: begin
				res = {val[W-2:0], val[W-1]};
				cout = val[W-1];
			end
			OP_ROTATE_RIGHT: begin
				res = {val[0], val[W-1:1]};
				cout = val[0];
			end
			OP_ROTATE_LEFT_VIA_CARRY: begin
				res = {val[W-2:0], cin};
				cout = val[W-1];
			end
			OP_ROTATE_RIGHT_VIA_CARRY: begin
				res = {cin, val[W-1:1]};
				cout = val[0];
			end
			default: begin
				res = val;
			end
		endcase
	end
endmodule

// file: src/alu_muldiv_unit.sv
// Unsigned byte multiplier and word-by-byte divider.
`timescale 1ns/100ps
module alu_muldiv_unit #(
	parameter int W = 8
) (
	input wire logic [2*W-1:0] dividend,
	input wire logic [W-1:0] mul_a,
	input wire logic [W-1:0] divisor,
	output logic [2*W-1:0] product,
	output logic [W-1:0] quotient,
	output logic [W-1:0] remainder
);
	logic [2*W-1:0] q_full;
	logic [2*W-1:0] r_full;

	assign product = {{W{1'b0}}, mul_a} * {{W{1'b0}}, divisor};
	// A zero divisor would make an undefined result, so it gives all ones and the low dividend.
	assign q_full = (divisor == '0) ? '1 : dividend / {{W{1'b0}}, divisor};
	assign r_full = (divisor == '0) ? dividend : dividend % {{W{1'b0}}, divisor};
	// A quotient above one byte is cut to its low byte; software must avoid that case.
	assign quotient = q_full[W-1:0];
	assign remainder = r_full[W-1:0];
endmodule

// file: verif/alu_regfile_model.sv
// Behavioural destination register and flag register fed by the datapath.
`timescale 1ns/100ps
module alu_regfile_model
	import alu_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic fl_en,
	input wire logic [FLG_W-1:0] fl_data,
	output logic [DATA_W-1:0] dest_ff,
	output logic [FLG_W-1:0] ccr_ff
);
	// The register only changes on a write pulse, so a refused request leaves it alone.
	always_ff @(posedge clock) begin
		if (rst) begin
			dest_ff <= 16'h0000;
		end else if (wr_en) begin
			dest_ff <= wr_data;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			ccr_ff <= 5'h00;
		end else if (fl_en) begin
			ccr_ff <= fl_data;
		end
	end
endmodule

// file: verif/tb_top.sv
// Self-checking testbench for the execution datapath.
`timescale 1ns/100ps
module tb_top
	import alu_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic in_valid = 1'b0;
	alu_op_t op_in = OP_ADD;
	logic size_word = 1'b0;
	logic use_imm = 1'b0;
	logic bit_from_reg = 1'b0;
	logic [2:0] bit_num_imm = 3'h0;
	logic [15:0] rd_val = 16'h0000;
	logic [15:0] rs_val = 16'h0000;
	logic [15:0] imm_val = 16'h0000;
	logic [4:0] flags_in = 5'h00;
	logic out_valid_ff, result_write_ff, illegal_ff;
	logic [15:0] result_ff, dest_ff;
	logic [4:0] flags_ff, ccr_ff;
	int fail_count = 0;
	int checks = 0;

	always #5 clock = ~clock;

	alu_datapath dut_u (.clock(clock), .rst(rst), .in_valid(in_valid), .op_in(op_in),
		.size_word(size_word), .use_imm(use_imm), .bit_from_reg(bit_from_reg),
		.bit_num_imm(bit_num_imm), .rd_val(rd_val), .rs_val(rs_val), .imm_val(imm_val),
		.flags_in(flags_in), .out_valid_ff(out_valid_ff), .result_ff(result_ff),
		.result_write_ff(result_write_ff), .flags_ff(flags_ff), .illegal_ff(illegal_ff));
	alu_regfile_model reg_u (.clock(clock), .rst(rst), .wr_en(result_write_ff),
		.wr_data(result_ff), .fl_en(out_valid_ff), .fl_data(flags_ff), .dest_ff(dest_ff),
		.ccr_ff(ccr_ff));

	task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp5(input string nm, input logic [4:0] e, input logic [4:0] g);
		cmp16(nm, {11'h000, e}, {11'h000, g});
	endtask
	task automatic cmp1(input string nm, input logic e, input logic g);
		cmp16(nm, {15'h0000, e}, {15'h0000, g});
	endtask

	// One request held for exactly one edge; outputs are read once that edge has landed.
	task automatic do_op(input alu_op_t op, input logic w, input logic im, input logic br,
		input logic [2:0] bn, input logic [15:0] rd, input logic [15:0] rs,
		input logic [15:0] iv, input logic [4:0] fi);
		@(posedge clock);
		in_valid <= 1'b1;
		op_in <= op;
		size_word <= w;
		use_imm <= im;
		bit_from_reg <= br;
		bit_num_imm <= bn;
		rd_val <= rd;
		rs_val <= rs;
		imm_val <= iv;
		flags_in <= fi;
		@(posedge clock);
		in_valid <= 1'b0;
		#1;
	endtask
	task automatic chk_res(input string nm, input logic [15:0] e, input logic wr);
		cmp1({nm, " valid"}, 1'b1, out_valid_ff);
		cmp1({nm, " illegal"}, 1'b0, illegal_ff);
		cmp1({nm, " write"}, wr, result_write_ff);
		if (wr) cmp16({nm, " result"}, e, result_ff);
	endtask
	task automatic chk_ill(input string nm, input logic [15:0] rd, input logic [4:0] fi);
		cmp1({nm, " illegal"}, 1'b1, illegal_ff);
		cmp1({nm, " write"}, 1'b0, result_write_ff);
		cmp16({nm, " result"}, rd, result_ff);
		cmp5({nm, " flags"}, fi, flags_ff);
	endtask

	task automatic test_reset;
		cmp1("reset valid", 1'b0, out_valid_ff);
		cmp1("reset write", 1'b0, result_write_ff);
		cmp1("reset illegal", 1'b0, illegal_ff);
		cmp16("reset result", 16'h0000, result_ff);
		cmp5("reset flags", 5'h00, flags_ff);
		$display("test_reset done");
	endtask

	task automatic test_add_sub;
		do_op(OP_ADD, 0, 0, 0, 0, 16'h0012, 16'h0034, 0, 5'h00);
		chk_res("add reg", 16'h0046, 1);
		@(posedge clock);
		#1;
		cmp16("dest reg", 16'h0046, dest_ff);
		do_op(OP_ADD, 0, 1, 0, 0, 16'h00ff, 0, 16'h0001, 5'h00);
		chk_res("add imm", 16'h0000, 1);
		cmp5("add imm flags", 5'h15, flags_ff);
		@(posedge clock);
		#1;
		cmp5("ccr reg", 5'h15, ccr_ff);
		do_op(OP_SUB, 0, 1, 0, 0, 16'h0050, 0, 16'h0001, 5'h0a);
		chk_ill("sub imm", 16'h0050, 5'h0a);
		do_op(OP_ADD, 1, 1, 0, 0, 16'h1234, 0, 16'h0001, 5'h01);
		chk_ill("word add imm", 16'h1234, 5'h01);
		do_op(OP_ADD, 1, 0, 0, 0, 16'h1234, 16'h0fff, 0, 5'h00);
		chk_res("word add", 16'h2233, 1);
		do_op(OP_SUB, 1, 0, 0, 0, 16'h1234, 16'h0234, 0, 5'h00);
		chk_res("word sub", 16'h1000, 1);
		$display("test_add_sub done");
	endtask

	task automatic test_carry_step;
		do_op(OP_ADD_CARRY, 0, 0, 0, 0, 16'h0010, 16'h0020, 0, 5'h01);
		chk_res("add carry", 16'h0031, 1);
		do_op(OP_SUB_CARRY, 0, 1, 0, 0, 16'h0031, 0, 16'h0020, 5'h01);
		chk_res("sub carry imm", 16'h0010, 1);
		do_op(OP_INC, 0, 0, 0, 0, 16'h007f, 0, 0, 5'h00);
		chk_res("inc", 16'h0080, 1);
		cmp5("inc flags", 5'h0a, flags_ff);
		do_op(OP_DEC, 0, 0, 0, 0, 16'h0000, 0, 0, 5'h00);
		chk_res("dec", 16'h00ff, 1);
		do_op(OP_WORD_ADD_STEP, 1, 1, 0, 0, 16'hfffe, 0, 16'h0002, 5'h00);
		chk_res("word add two", 16'h0000, 1);
		do_op(OP_WORD_SUB_STEP, 1, 1, 0, 0, 16'h0000, 0, 16'h0001, 5'h00);
		chk_res("word sub one", 16'hffff, 1);
		do_op(OP_WORD_ADD_STEP, 1, 1, 0, 0, 16'h0100, 0, 16'h0003, 5'h04);
		chk_ill("word add three", 16'h0100, 5'h04);
		$display("test_carry_step done");
	endtask

	task automatic test_dec_muldiv;
		do_op(OP_DEC_ADJ_ADD, 0, 0, 0, 0, 16'h003c, 0, 0, 5'h00);
		chk_res("adjust add", 16'h0042, 1);
		do_op(OP_DEC_ADJ_SUB, 0, 0, 0, 0, 16'h002d, 0, 0, 5'h10);
		chk_res("adjust sub", 16'h0027, 1);
		do_op(OP_MUL, 0, 0, 0, 0, 16'h00ff, 16'h00ff, 0, 5'h00);
		chk_res("mul", 16'hfe01, 1);
		do_op(OP_DIV, 0, 0, 0, 0, 16'h1234, 16'h0056, 0, 5'h00);
		chk_res("div", 16'h1036, 1);
		$display("test_dec_muldiv done");
	endtask

	task automatic test_cmp_neg;
		do_op(OP_CMP, 0, 1, 0, 0, 16'h0005, 0, 16'h0005, 5'h00);
		chk_res("cmp", 16'h0000, 0);
		cmp5("cmp flags", 5'h04, flags_ff);
		do_op(OP_CMP, 1, 1, 0, 0, 16'h0300, 0, 16'h0001, 5'h02);
		chk_ill("word cmp imm", 16'h0300, 5'h02);
		do_op(OP_NEG, 0, 0, 0, 0, 16'h0001, 0, 0, 5'h00);
		chk_res("neg", 16'h00ff, 1);
		do_op(OP_NOT, 0, 0, 0, 0, 16'h005a, 0, 0, 5'h00);
		chk_res("not", 16'h00a5, 1);
		do_op(OP_AND, 0, 0, 0, 0, 16'h00f0, 16'h003c, 0, 5'h00);
		chk_res("and", 16'h0030, 1);
		do_op(OP_OR, 0, 1, 0, 0, 16'h00f0, 0, 16'h003c, 5'h00);
		chk_res("or imm", 16'h00fc, 1);
		do_op(OP_XOR, 0, 0, 0, 0, 16'h00f0, 16'h003c, 0, 5'h00);
		chk_res("xor", 16'h00cc, 1);
		$display("test_cmp_neg done");
	endtask

	task automatic test_shift;
		alu_op_t ops[8] = '{OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT,
			OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
			OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY};
		logic [7:0] res[8] = '{8'h82, 8'h20, 8'h82, 8'h20, 8'h82, 8'ha0, 8'h83, 8'ha0};
		for (int i = 0; i < 8; i++) begin
			do_op(ops[i], 0, 0, 0, 0, 16'h0041, 0, 0, 5'h01);
			chk_res("shift", {8'h00, res[i]}, 1);
			cmp1("shift carry", i[0], flags_ff[FC]);
		end
		$display("test_shift done");
	endtask

	task automatic test_bit;
		logic [4:0] cexp[5] = '{5'h01, 5'h00, 5'h01, 5'h01, 5'h00};
		alu_op_t cops[5] = '{OP_CARRY_AND_BIT, OP_CARRY_AND_INV_BIT, OP_CARRY_OR_BIT,
			OP_CARRY_OR_INV_BIT, OP_CARRY_XOR_BIT};
		do_op(OP_BIT_SET, 0, 0, 0, 3'h2, 16'h12f0, 0, 0, 5'h00);
		chk_res("bit set", 16'h00f4, 1);
		do_op(OP_BIT_CLEAR, 0, 0, 1, 3'h0, 16'h00f0, 16'h000d, 0, 5'h00);
		chk_res("bit clear reg", 16'h00d0, 1);
		do_op(OP_BIT_INVERT, 0, 0, 0, 3'h7, 16'h00f0, 0, 0, 5'h00);
		chk_res("bit invert", 16'h0070, 1);
		do_op(OP_BIT_TEST, 0, 0, 0, 3'h0, 16'h0001, 0, 0, 5'h04);
		chk_res("bit test one", 16'h0000, 0);
		cmp1("test zero", 1'b0, flags_ff[FZ]);
		do_op(OP_BIT_TEST, 0, 0, 1, 3'h0, 16'h0001, 16'h0009, 0, 5'h00);
		cmp1("test zero reg", 1'b1, flags_ff[FZ]);
		for (int i = 0; i < 5; i++) begin
			do_op(cops[i], 0, 0, 0, 3'h2, 16'h0004, 0, 0, 5'h01);
			chk_res("carry bit", 16'h0000, 0);
			cmp1("carry bit flag", cexp[i][0], flags_ff[FC]);
		end
		do_op(OP_CARRY_OR_INV_BIT, 0, 0, 1, 3'h2, 16'h0004, 16'h0002, 0, 5'h08);
		chk_ill("inv bit from reg", 16'h0004, 5'h08);
		$display("test_bit done");
	endtask

	task automatic test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// The whole sequence takes well under a thousand cycles, so this limit only trips on a hang.
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		test_done();
	end

	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		#1;
		test_reset();
		test_add_sub();
		test_carry_step();
		test_dec_muldiv();
		test_cmp_neg();
		test_shift();
		test_bit();
		test_done();
	end
endmodule
